// file: src/pirq_pkg.sv
package pirq_pkg;

	// ****************************************************************
	// Register map (byte addresses, one aligned word each)
	// ****************************************************************
	localparam logic [7:0] ADDR_ENABLE_1   = 8'h00;
	localparam logic [7:0] ADDR_ENABLE_2   = 8'h04;
	localparam logic [7:0] ADDR_PRIORITY_1 = 8'h08;
	localparam logic [7:0] ADDR_PRIORITY_2 = 8'h0c;
	localparam logic [7:0] ADDR_RESET_CTRL = 8'h10;
	localparam logic [7:0] ADDR_FLAG_1     = 8'h14;
	localparam logic [7:0] ADDR_FLAG_2     = 8'h18;
	localparam logic [7:0] ADDR_GLOBAL     = 8'h1c;

	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam logic [7:0] MASK_GROUP_1    = 8'h7f;
	localparam logic [7:0] MASK_GROUP_2    = 8'hfe;
	localparam logic [7:0] RST_ENABLE      = 8'h00;
	localparam logic [7:0] RST_PRIO_1      = 8'h7f;
	localparam logic [7:0] RST_PRIO_2      = 8'hfe;
	localparam int         BIT_PLEV        = 7;
	localparam int         BIT_SBOR        = 6;
	localparam int         BIT_RINS        = 4;
	localparam int         BIT_WDTO        = 3;
	localparam int         BIT_PDWN        = 2;
	localparam int         BIT_PON         = 1;
	localparam int         BIT_BOR         = 0;
	localparam int         BIT_GLOBAL_EN   = 0;
	localparam int         BIT_GROUP_EN    = 1;
	localparam logic [1:0] BOR_CFG_SW      = 2'h1;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic watchdog_clear_instr;
		logic sleep_instr;
		logic reset_instr;
		logic watchdog_timeout;
		logic power_on_reset;
		logic brownout_reset;
	} pirq_evt_s;

	typedef struct packed {
		logic       priority_levels_enable;
		logic       sw_brownout_enable;
		logic       reset_instr_flag;
		logic       watchdog_timeout_flag;
		logic       power_down_flag;
		logic       power_on_flag;
		logic       brownout_status_flag;
	} pirq_reset_cause_control_s;

endpackage

// file: src/pirq_regmem.sv
`timescale 1ns/10ps

// ****************************************************************
// Small register bank with registered read data and bit masks
// ****************************************************************
module pirq_regmem #(
	parameter int         W     = 8,
	parameter logic [W-1:0] MASK  = '1,
	parameter logic [W-1:0] RESET = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Write port
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	// Contents
	output logic      [W-1:0] q
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb
	begin
		q_next = q_reg;
		if (wr_en)
		begin
			q_next = wr_data & MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			q_reg <= RESET & MASK;
		else
			q_reg <= q_next;
	end

	assign q = q_reg;

endmodule // pirq_regmem

// file: src/pirq_top.sv
`timescale 1ns/10ps

// Contract
// - Enable register two holds seven read/write enables in bits 7 to 1.
// - Bit 0 of enable two and priority two reads zero, ignores writes.
// - Priority bits steer routing only while priority levels are enabled.
// - Priority register one holds seven priorities, bits 6 to 0; bit 7 zero.
// - Priority register two holds seven priorities in bits 7 to 1.
// - Priorities reset to one; enables in enable register two reset to zero.
// - Reset-control bit 7 enables two levels; resets to zero.
// - Bit 6 software brown-out enable works only when config is 01.
// - Reset-instruction flag clears on reset instruction; resets to one.
// - Watchdog flag read-only: set on power-up, clear, sleep; cleared on timeout.
// - Power-down flag read-only: set on power-up, clear; cleared by sleep.
// - Power-on flag cleared by power-on reset; software writes it back to one.
// - Brown-out flag cleared by brown-out reset; only firmware sets it.
// - Reset-control shows reset and wake cause; bit 5 reads zero.
// - Without priority levels, group enable also gates peripheral requests.
// - Flags set on their condition regardless of any enable.
module pirq_top (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// AXI4-Lite write
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Peripheral events, one-cycle pulses on clk
	input  wire logic [7:0]        periph_evt_1,
	input  wire logic [7:0]        periph_evt_2,
	// Reset and power logic
	input  wire pirq_pkg::pirq_evt_s sys_evt,
	input  wire logic [1:0]        brownout_config_field,
	// Outputs to the core
	output logic                   irq_high,
	output logic                   irq_low,
	output logic                   brownout_sw_on
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic       aw_held;
		logic [7:0] aw_addr;
		logic       w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] flag_1;
		logic [7:0] flag_2;
		logic       global_en;
		logic       peripheral_group_enable;
		pirq_pkg::pirq_reset_cause_control_s reset_cause_control;
		logic       irq_high;
		logic       irq_low;
		logic       bor_on;
		logic       awready;
		logic       wready;
		logic       arready;
	} pirq_state_s;

	pirq_state_s st_reg;
	pirq_state_s st_next;

	logic [7:0] en_1;
	logic [7:0] en_2;
	logic [7:0] prio_1;
	logic [7:0] prio_2;
	logic       wr_fire;
	logic       wr_lane0;
	logic [7:0] wr_byte;
	localparam int N_BANK = 4;
	// Bank order: enable 1, enable 2, priority 1, priority 2
	localparam logic [N_BANK-1:0][7:0] BANK_ADDR = {
		pirq_pkg::ADDR_PRIORITY_2, pirq_pkg::ADDR_PRIORITY_1,
		pirq_pkg::ADDR_ENABLE_2, pirq_pkg::ADDR_ENABLE_1};
	localparam logic [N_BANK-1:0][7:0] BANK_MASK = {
		pirq_pkg::MASK_GROUP_2, pirq_pkg::MASK_GROUP_1,
		pirq_pkg::MASK_GROUP_2, pirq_pkg::MASK_GROUP_1};
	localparam logic [N_BANK-1:0][7:0] BANK_RST = {
		pirq_pkg::RST_PRIO_2, pirq_pkg::RST_PRIO_1,
		pirq_pkg::RST_ENABLE, pirq_pkg::RST_ENABLE};
	logic [N_BANK-1:0][7:0] bank_q;
	logic [N_BANK-1:0]      bank_hit;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// Any mapped register, for the response code of both channels
	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, pirq_pkg::ADDR_ENABLE_1)
			|| hit(a, pirq_pkg::ADDR_ENABLE_2)
			|| hit(a, pirq_pkg::ADDR_PRIORITY_1)
			|| hit(a, pirq_pkg::ADDR_PRIORITY_2)
			|| hit(a, pirq_pkg::ADDR_RESET_CTRL)
			|| hit(a, pirq_pkg::ADDR_FLAG_1)
			|| hit(a, pirq_pkg::ADDR_FLAG_2)
			|| hit(a, pirq_pkg::ADDR_GLOBAL);
	endfunction

	// Decode of the write once both halves are held
	assign wr_fire  = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
	assign wr_lane0 = wr_fire && st_reg.w_strb[0];
	assign wr_byte  = st_reg.w_data[7:0];

	// ****************************************************************
	// Enable and priority banks
	// ****************************************************************
	// Masks drop unimplemented bits: they read zero and lose writes
	generate
		for (genvar i = 0; i < N_BANK; i++)
		begin : g_bank
			assign bank_hit[i] = hit(st_reg.aw_addr, BANK_ADDR[i]);
			pirq_regmem #(.W(8), .MASK(BANK_MASK[i]),
				.RESET(BANK_RST[i])) u_bank (
				.clk     (clk),
				.srst    (srst),
				.wr_en   (wr_lane0 && bank_hit[i]),
				.wr_data (wr_byte),
				.q       (bank_q[i])
			);
		end
	endgenerate
	assign en_1   = bank_q[0];
	assign en_2   = bank_q[1];
	assign prio_1 = bank_q[2];
	assign prio_2 = bank_q[3];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic [7:0] reset_cause_control_rd;
		logic [7:0] act_1;
		logic [7:0] act_2;
		logic [7:0] rd;
		logic       sw_bor_cfg;
		logic       plev;
		logic       hi;
		logic       lo;
		reset_cause_control_rd = '0;
		act_1 = '0;
		act_2 = '0;
		rd = '0;
		hi = 1'b0;
		lo = 1'b0;
		st_next = st_reg;
		sw_bor_cfg = (brownout_config_field == pirq_pkg::BOR_CFG_SW);
		plev = st_reg.reset_cause_control.priority_levels_enable;

		// Write channels are accepted independently, in either order
		if (s_axi_awvalid && !st_reg.aw_held)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_held)
		begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;

		// Software writes (flag registers 1 and 2 are write-to-clear by writing zero)
		if (wr_fire)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = mapped(st_reg.aw_addr) ? pirq_pkg::RESP_OKAY
				: pirq_pkg::RESP_SLVERR;
		end
		// Only byte lane 0 carries register bits
		if (wr_lane0)
		begin
			if (hit(st_reg.aw_addr, pirq_pkg::ADDR_RESET_CTRL))
			begin
				st_next.reset_cause_control.priority_levels_enable
					= wr_byte[pirq_pkg::BIT_PLEV];
				if (sw_bor_cfg)
					st_next.reset_cause_control.sw_brownout_enable
						= wr_byte[pirq_pkg::BIT_SBOR];
				st_next.reset_cause_control.reset_instr_flag
					= wr_byte[pirq_pkg::BIT_RINS];
				st_next.reset_cause_control.power_on_flag
					= wr_byte[pirq_pkg::BIT_PON];
				st_next.reset_cause_control.brownout_status_flag
					= wr_byte[pirq_pkg::BIT_BOR];
			end
			else if (hit(st_reg.aw_addr, pirq_pkg::ADDR_FLAG_1))
				st_next.flag_1 = st_reg.flag_1 & wr_byte;
			else if (hit(st_reg.aw_addr, pirq_pkg::ADDR_FLAG_2))
				st_next.flag_2 = st_reg.flag_2 & wr_byte;
			else if (hit(st_reg.aw_addr, pirq_pkg::ADDR_GLOBAL))
			begin
				st_next.global_en = wr_byte[pirq_pkg::BIT_GLOBAL_EN];
				st_next.peripheral_group_enable
					= wr_byte[pirq_pkg::BIT_GROUP_EN];
			end
		end

		// Events override a same-cycle software clear
		st_next.flag_1 = (st_next.flag_1 | periph_evt_1)
			& pirq_pkg::MASK_GROUP_1;
		st_next.flag_2 = (st_next.flag_2 | periph_evt_2)
			& pirq_pkg::MASK_GROUP_2;

		// Hardware cause updates take effect over software writes
		if (sys_evt.reset_instr)
			st_next.reset_cause_control.reset_instr_flag = 1'b0;
		if (sys_evt.watchdog_clear_instr)
		begin
			st_next.reset_cause_control.watchdog_timeout_flag = 1'b1;
			st_next.reset_cause_control.power_down_flag = 1'b1;
		end
		if (sys_evt.sleep_instr)
		begin
			st_next.reset_cause_control.watchdog_timeout_flag = 1'b1;
			st_next.reset_cause_control.power_down_flag = 1'b0;
		end
		if (sys_evt.watchdog_timeout)
			st_next.reset_cause_control.watchdog_timeout_flag = 1'b0;
		if (sys_evt.brownout_reset)
			st_next.reset_cause_control.brownout_status_flag = 1'b0;
		if (sys_evt.power_on_reset)
		begin
			st_next.reset_cause_control.power_on_flag = 1'b0;
			st_next.reset_cause_control.watchdog_timeout_flag = 1'b1;
			st_next.reset_cause_control.power_down_flag = 1'b1;
		end

		// Reset-control read view; bit 5 stays zero
		reset_cause_control_rd[pirq_pkg::BIT_PLEV] = st_reg.reset_cause_control.priority_levels_enable;
		reset_cause_control_rd[pirq_pkg::BIT_SBOR] = sw_bor_cfg
			&& st_reg.reset_cause_control.sw_brownout_enable;
		reset_cause_control_rd[pirq_pkg::BIT_RINS] = st_reg.reset_cause_control.reset_instr_flag;
		reset_cause_control_rd[pirq_pkg::BIT_WDTO] = st_reg.reset_cause_control.watchdog_timeout_flag;
		reset_cause_control_rd[pirq_pkg::BIT_PDWN] = st_reg.reset_cause_control.power_down_flag;
		reset_cause_control_rd[pirq_pkg::BIT_PON]  = st_reg.reset_cause_control.power_on_flag;
		reset_cause_control_rd[pirq_pkg::BIT_BOR]  = st_reg.reset_cause_control.brownout_status_flag;
		st_next.bor_on = reset_cause_control_rd[pirq_pkg::BIT_SBOR];

		// Read channel: one read in flight, answered a cycle later
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (s_axi_arvalid && !st_reg.rvalid)
		begin
			if (hit(s_axi_araddr, pirq_pkg::ADDR_ENABLE_1))
				rd = en_1;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_ENABLE_2))
				rd = en_2;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_PRIORITY_1))
				rd = prio_1;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_PRIORITY_2))
				rd = prio_2;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_RESET_CTRL))
				rd = reset_cause_control_rd;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_FLAG_1))
				rd = st_reg.flag_1;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_FLAG_2))
				rd = st_reg.flag_2;
			else if (hit(s_axi_araddr, pirq_pkg::ADDR_GLOBAL))
			begin
				rd[pirq_pkg::BIT_GLOBAL_EN] = st_reg.global_en;
				rd[pirq_pkg::BIT_GROUP_EN] = st_reg.peripheral_group_enable;
			end
			st_next.rvalid = 1'b1;
			st_next.rdata = {24'h000000, rd};
			st_next.rresp = mapped(s_axi_araddr) ? pirq_pkg::RESP_OKAY
				: pirq_pkg::RESP_SLVERR;
		end

		// ****************************************************************
		// Request routing
		// ****************************************************************
		act_1 = st_reg.flag_1 & en_1;
		act_2 = st_reg.flag_2 & en_2;
		if (plev)
		begin
			// Two levels; a priority bit picks the line
			hi = st_reg.global_en
				&& |((act_1 & prio_1) | (act_2 & prio_2));
			lo = st_reg.peripheral_group_enable
				&& |((act_1 & ~prio_1) | (act_2 & ~prio_2));
		end
		else
		begin
			// One level; priority ignored, group gate required
			hi = st_reg.global_en && st_reg.peripheral_group_enable
				&& |(act_1 | act_2);
		end
		st_next.irq_high = hi;
		st_next.irq_low = lo;
		// Readies are registered so every port leaves a flip-flop
		st_next.awready = !st_next.aw_held;
		st_next.wready = !st_next.w_held;
		st_next.arready = !st_next.rvalid;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_reg <= '0;
			st_reg.reset_cause_control.reset_instr_flag <= 1'b1;
			st_reg.reset_cause_control.watchdog_timeout_flag <= 1'b1;
			st_reg.reset_cause_control.power_down_flag <= 1'b1;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// Ready is high while the holding slot is empty
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready  = st_reg.wready;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
	assign irq_high      = st_reg.irq_high;
	assign irq_low       = st_reg.irq_low;
	assign brownout_sw_on = st_reg.bor_on;

endmodule // pirq_top

// file: test/pirq_chk.sv
`timescale 1ns/10ps

// ************
// Port checks
// ************
module pirq_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Core side
	input wire logic [1:0]  brownout_config_field,
	input wire logic        irq_high,
	input wire logic        irq_low,
	input wire logic        brownout_sw_on
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped early");

	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped early");

	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat)
		else $error("read answer late");

	property p_bans;
		!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid;
	endproperty
	a_bans: assert property (p_bans)
		else $error("write answer late");

	property p_arblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arblk: assert property (p_arblk)
		else $error("read taken while answer pending");

	// Registers are one byte wide: upper lanes must never carry stale bits
	property p_rup;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rup: assert property (p_rup)
		else $error("read data upper bits set");

	property p_rst;
		$fell(srst) |-> !irq_high && !irq_low && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs active after reset");

	property p_sbor;
		$past(brownout_config_field) != pirq_pkg::BOR_CFG_SW |-> !brownout_sw_on;
	endproperty
	a_sbor: assert property (p_sbor)
		else $error("software brown-out on in wrong mode");

	c_high: cover property (irq_high);
	c_low: cover property (irq_low);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == pirq_pkg::RESP_SLVERR);
endmodule // pirq_chk

bind pirq_top pirq_chk u_chk (
	.clk(clk), .srst(srst), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.brownout_config_field(brownout_config_field),
	.irq_high(irq_high), .irq_low(irq_low), .brownout_sw_on(brownout_sw_on)
);

// file: test/pirq_src_model.sv
`timescale 1ns/10ps

// ************
// Event sources
// ************
module pirq_src_model (
	// Clock
	input  wire logic           clk,
	// Request from the bench
	input  wire logic           go,
	input  wire logic [7:0]     p1,
	input  wire logic [7:0]     p2,
	input  wire logic [5:0]     se,
	// Pulses into the block
	output logic [7:0]          periph_evt_1 = 8'h00,
	output logic [7:0]          periph_evt_2 = 8'h00,
	output pirq_pkg::pirq_evt_s sys_evt = '0
);
	// Strictly one cycle: a held event would read as a repeat
	always @(posedge clk)
	begin
		periph_evt_1 <= go ? p1 : 8'h00;
		periph_evt_2 <= go ? p2 : 8'h00;
		sys_evt      <= go ? se : 6'h00;
	end
endmodule // pirq_src_model

// file: test/pirq_tb.sv
`timescale 1ns/10ps

module pirq_tb;
	logic                clk, srst, go, awv, awr, wv, wr, bv, bq;
	logic                arv, arr, rv, rq, ih, il, bso;
	logic [7:0]          awa, ara, e1, e2, p1, p2, rb;
	logic [31:0]         wd, rd;
	logic [3:0]          ws;
	logic [1:0]          bs, rs, cfg;
	logic [5:0]          se;
	pirq_pkg::pirq_evt_s sev;
	int                  bad_count, n_tests;
	int                  cyc = 0;

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	pirq_top uut (
		.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bs),
		.s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rs), .s_axi_rvalid(rv), .s_axi_rready(rq),
		.periph_evt_1(e1), .periph_evt_2(e2), .sys_evt(sev),
		.brownout_config_field(cfg), .irq_high(ih), .irq_low(il),
		.brownout_sw_on(bso)
	);

	pirq_src_model u_src (
		.clk(clk), .go(go), .p1(p1), .p2(p2), .se(se),
		.periph_evt_1(e1), .periph_evt_2(e2), .sys_evt(sev)
	);

	task automatic chk(input string nm, input logic [31:0] g,
		input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr8(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= {24'h000000, d};
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		bq <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge clk);
			if (awv && awr)
			begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr)
			begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (!bv);
		bq <= 1'b0;
		chk("bresp", bs, er);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [7:0] e);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rq <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rb = rd[7:0];
		rq <= 1'b0;
		chk(nm, rb, e);
		chk("rresp", rs, a > pirq_pkg::ADDR_GLOBAL ? 2'h2 : 2'h0);
	endtask

	task automatic pulse(input logic [7:0] a, input logic [7:0] b,
		input logic [5:0] s);
		@(posedge clk);
		go <= 1'b1;
		p1 <= a;
		p2 <= b;
		se <= s;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Write lands on the same edge as the answer, the request one edge later
	task automatic wt;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset;
		rchk("en2", 8'h04, 8'h00);
		rchk("pr1", 8'h08, 8'h7f);
		rchk("pr2", 8'h0c, 8'hfe);
		rchk("reset_cause_control", 8'h10, 8'h1c);
	endtask

	task automatic t_regs;
		wr8(8'h04, 8'hff, 2'h0);
		rchk("en2", 8'h04, 8'hfe);
		wr8(8'h08, 8'hff, 2'h0);
		rchk("pr1", 8'h08, 8'h7f);
		wr8(8'h0c, 8'h00, 2'h0);
		rchk("pr2", 8'h0c, 8'h00);
		wr8(8'h0c, 8'hff, 2'h0);
		rchk("pr2", 8'h0c, 8'hfe);
		wr8(8'h20, 8'hff, 2'h2);
		rchk("none", 8'h20, 8'h00);
		wr8(8'h10, 8'hff, 2'h0);
		rchk("reset_cause_control", 8'h10, 8'h9f);
		@(posedge clk);
		cfg <= 2'h1;
		wr8(8'h10, 8'hff, 2'h0);
		rchk("reset_cause_control", 8'h10, 8'hdf);
		chk("bso", bso, 32'h1);
		for (int c = 2; c < 4; c++)
		begin
			@(posedge clk);
			cfg <= c[1:0];
			rchk("reset_cause_control", 8'h10, 8'h9f);
			chk("bso", bso, 32'h0);
		end
	endtask

	task automatic t_evts;
		logic [5:0] ev [6] = '{6'h08, 6'h04, 6'h20, 6'h10, 6'h01, 6'h02};
		logic [7:0] ex [6] = '{8'h8f, 8'h87, 8'h8f, 8'h8b, 8'h8a, 8'h8c};
		for (int i = 0; i < 6; i++)
		begin
			pulse(8'h00, 8'h00, ev[i]);
			rchk("reset_cause_control", 8'h10, ex[i]);
		end
	endtask

	task automatic t_irq;
		wr8(8'h04, 8'h02, 2'h0);
		wr8(8'h1c, 8'h01, 2'h0);
		pulse(8'h00, 8'h03, 6'h00);
		rchk("flag2", 8'h18, 8'h02);
		chk("high", ih, 32'h1);
		chk("low", il, 32'h0);
		wr8(8'h0c, 8'hfc, 2'h0);
		wt;
		chk("high", ih, 32'h0);
		chk("low", il, 32'h0);
		wr8(8'h1c, 8'h03, 2'h0);
		wt;
		chk("low", il, 32'h1);
		wr8(8'h10, 8'h7f, 2'h0);
		wt;
		chk("low", il, 32'h0);
		chk("high", ih, 32'h1);
		wr8(8'h1c, 8'h01, 2'h0);
		wt;
		chk("high", ih, 32'h0);
		pulse(8'hc0, 8'h00, 6'h00);
		rchk("flag1", 8'h14, 8'h40);
		wr8(8'h18, 8'h00, 2'h0);
		wr8(8'h00, 8'h40, 2'h0);
		wr8(8'h1c, 8'h03, 2'h0);
		wt;
		chk("high", ih, 32'h1);
		wr8(8'h14, 8'h00, 2'h0);
		rchk("flag1", 8'h14, 8'h00);
		chk("high", ih, 32'h0);
	endtask

	task automatic tally_and_finish;
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			tally_and_finish;
		end
	end

	initial
	begin
		{srst, go, awv, wv, bq, arv, rq} = 7'h40;
		{awa, ara, p1, p2, se, cfg, ws} = '0;
		wd = 32'h00000000;
		bad_count = 0;
		n_tests = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_regs;
		t_evts;
		t_irq;
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		tally_and_finish;
	end
endmodule // pirq_tb
